// ===== hw/cicsp_top.sv
// top of the stream port block: sink, source and apb registers
`timescale 1ns/1ps

// Summary of operation
// - interface zero sits in top slot
// - all registers run on one clock
// - clock enable gates every advance
// - two-bit error code, shared encoding
// - sink ready only when beat fits
// - start marker means channel zero
// - without sink valid, processing waits
// - one sample port per interface
// - channel index travels with result
// - parameter width, one result port each
// - end marker on last channel result
// - source error uses same code
// - start marker on channel zero result
// - beat moves when valid meets ready
// - source valid only with result
module cicsp_top #(
  parameter int NUM_IF = cicsp_pkg::NUM_IF_DEFAULT,        // parallel interfaces
  parameter int NUM_CH = cicsp_pkg::NUM_CH_DEFAULT,        // channels per interface
  parameter int IN_W   = cicsp_pkg::IN_W_DEFAULT,          // sample width
  parameter int OUT_W  = cicsp_pkg::OUT_W_DEFAULT,         // result width
  parameter int CH_W   = (NUM_CH > 1) ? $clog2(NUM_CH) : 1 // channel index width
) (
  input  wire logic                         pclk,                // the only clock
  input  wire logic                         presetn,             // async reset, low
  input  wire logic [cicsp_pkg::ADDR_W-1:0] paddr,               // apb address
  input  wire logic                         psel,                // apb select
  input  wire logic                         penable,             // apb access phase
  input  wire logic                         pwrite,              // apb write
  input  wire logic [cicsp_pkg::DATA_W-1:0] pwdata,              // apb write data
  input  wire logic [cicsp_pkg::STRB_W-1:0] pstrb,               // apb byte strobes
  output logic      [cicsp_pkg::DATA_W-1:0] prdata,              // apb read data
  output logic                              pready,              // apb ready
  output logic                              pslverr,             // apb error
  input  wire logic                         clken,               // advance enable
  input  wire logic [IN_W-1:0]              sample_input_port [NUM_IF], // samples
  input  wire logic                         sink_valid,          // sample valid
  input  wire logic                         sink_sop,            // start marker
  input  wire logic                         sink_eop,            // end marker
  input  wire logic [1:0]                   sink_error,          // upstream error
  output logic                              sink_ready,          // sample taken
  output logic      [NUM_IF*IN_W-1:0]       sink_aggregate_bus,  // last samples packed
  output logic      [OUT_W-1:0]             result_output_port [NUM_IF], // results
  output logic      [NUM_IF*OUT_W-1:0]      source_aggregate_bus, // results packed
  output logic                              source_valid,        // result valid
  input  wire logic                         source_ready,        // downstream ready
  output logic                              source_sop,          // channel zero
  output logic                              source_eop,          // last channel
  output logic      [1:0]                   source_error,        // error code
  output logic      [CH_W-1:0]              source_channel       // result channel
);
  import cicsp_pkg::*;

  localparam logic [CH_W-1:0] FIRST_CH = '0;
  localparam logic [CH_W-1:0] LAST_CH  = CH_W'(NUM_CH - 1);

  // refuse shapes the datapath cannot serve
  if (NUM_IF < 1 || NUM_CH < 2 || IN_W < 2 || OUT_W < IN_W ||
      CH_W < $clog2(NUM_CH) || CH_W > CHAN_MAX_W) begin : g_bad_shape
    $error("unsupported parameter set");
  end

  cicsp_beat_if #(.CH_W(CH_W)) beat ();

  logic                    take;              // sink beat accepted
  logic                    pop;               // source beat delivered
  logic                    next_source_valid; // output slot full next cycle
  logic                    next_enable;       // enable after this edge
  logic                    ctrl_enable;       // software stream enable
  logic [STAT_W-1:0]       sticky;            // sticky error flags
  logic [STAT_W-1:0]       next_sticky;
  logic [DATA_W-1:0]       beat_count;        // taken sink beats
  logic [DATA_W-1:0]       rdata;             // read mux
  logic                    rd_bad;            // unmapped address
  logic                    apb_setup_done;    // access cycle waiting
  logic                    apb_done;          // transfer completes here
  logic                    wr_ctrl;
  logic                    wr_status;
  logic [NUM_IF*IN_W-1:0]  next_sink_bus;
  logic [NUM_IF*OUT_W-1:0] next_source_bus;
  logic [OUT_W-1:0]        next_result [NUM_IF];

  // waits for valid
  // the upstream keeps valid low while clken is low, the gate is a guard
  assign take = sink_valid & sink_ready & clken;
  assign pop  = source_valid & source_ready & clken;
  assign next_source_valid = take | (source_valid & ~pop);

  // beat seen by the framing checker
  assign beat.accept = take;
  assign beat.sop    = sink_sop;
  assign beat.eop    = sink_eop;
  assign beat.err_in = sink_error;

  cicsp_frame_check #(
    .NUM_CH (NUM_CH),
    .CH_W   (CH_W)
  ) u_check (
    .pclk    (pclk),
    .presetn (presetn),
    .beat    (beat.check)
  );

  for (genvar i = 0; i < NUM_IF; i++) begin : g_if
    localparam int SLOT = NUM_IF - 1 - i;
    // sign extension stands in for the filter arithmetic
    assign next_result[i] = OUT_W'($signed(sample_input_port[i]));
    assign next_sink_bus[SLOT*IN_W +: IN_W]    = sample_input_port[i];
    assign next_source_bus[SLOT*OUT_W +: OUT_W] = next_result[i];
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        result_output_port[i] <= '0;
      end else if (take) begin
        result_output_port[i] <= next_result[i];
      end
    end
  end

  // single clock
  // packed copies of the last taken beat, held like the results
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sink_aggregate_bus   <= '0;
      source_aggregate_bus <= '0;
    end else if (take) begin
      sink_aggregate_bus   <= next_sink_bus;
      source_aggregate_bus <= next_source_bus;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      source_valid <= 1'b0;
    end else begin
      source_valid <= next_source_valid;
    end
  end

  // ready when room
  // one output slot and a registered ready: at most one beat per two cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sink_ready <= 1'b0;
    end else begin
      sink_ready <= next_enable & ~next_source_valid;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      source_channel <= '0;
      source_sop     <= 1'b0;
      source_eop     <= 1'b0;
    end else if (take) begin
      source_channel <= beat.chan;
      source_sop     <= (beat.chan == FIRST_CH);
      source_eop     <= (beat.chan == LAST_CH);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      source_error <= ERR_NONE;
    end else if (take) begin
      source_error <= beat.err_out;
    end
  end

  // taken beat counter, wraps silently
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      beat_count <= '0;
    end else if (take) begin
      beat_count <= beat_count + DATA_W'(1);
    end
  end

  // apb handshake: one wait state, answer registered
  assign apb_setup_done = psel & penable & ~pready;
  assign apb_done       = psel & penable & pready;
  assign wr_ctrl   = apb_done & pwrite & pstrb[0] & (paddr == CTRL_OFFSET);
  assign wr_status = apb_done & pwrite & pstrb[0] & (paddr == STATUS_OFFSET);
  assign next_enable = wr_ctrl ? pwdata[CTRL_ENABLE_BIT] : ctrl_enable;

  // sticky flags: a new event beats a clear in the same cycle
  always_comb begin
    next_sticky = sticky;
    if (wr_status) begin
      next_sticky = sticky & ~pwdata[STAT_W-1:0];
    end
    if (take) begin
      case (beat.err_out)
        ERR_NO_SOP: next_sticky[STAT_NO_SOP_BIT] = 1'b1;
        ERR_NO_EOP: next_sticky[STAT_NO_EOP_BIT] = 1'b1;
        ERR_OTHER:  next_sticky[STAT_OTHER_BIT] = 1'b1;
        default:    next_sticky[STAT_OTHER_BIT] = sticky[STAT_OTHER_BIT] & ~wr_status |
                                                  next_sticky[STAT_OTHER_BIT];
      endcase
      if (sink_error != ERR_NONE) begin
        next_sticky[STAT_UPSTREAM_BIT] = 1'b1;
      end
    end
  end

  // sticky status register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sticky <= '0;
    end else begin
      sticky <= next_sticky;
    end
  end

  // control register, enable stops the sink from the edge that writes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_enable <= CTRL_ENABLE_RESET;
    end else begin
      ctrl_enable <= next_enable;
    end
  end

  // read mux, unused bits read as zero
  always_comb begin
    rdata  = '0;
    rd_bad = 1'b0;
    case (paddr)
      CTRL_OFFSET: begin
        rdata[CTRL_ENABLE_BIT] = ctrl_enable;
      end
      STATUS_OFFSET: begin
        rdata[STAT_W-1:0] = sticky;
      end
      CHAN_OFFSET: begin
        rdata[CH_W-1:0]             = beat.expect_chan;
        rdata[CHAN_SRC_LSB +: CH_W] = source_channel;
      end
      BEATS_OFFSET: begin
        rdata = beat_count;
      end
      default: begin
        rd_bad = 1'b1;
      end
    endcase
  end

  // apb ready rises one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= apb_setup_done;
    end
  end

  // apb answer latched with ready, held until the next access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (apb_setup_done) begin
      prdata  <= pwrite ? '0 : rdata;
      pslverr <= rd_bad;
    end
  end

  property p_ready_room;
    @(posedge pclk) disable iff (!presetn)
    sink_ready |-> !source_valid && ctrl_enable;
  endproperty
  a_ready_room: assert property (p_ready_room) else $error("ready with full slot");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    source_valid && !(source_ready && clken) |=>
      source_valid && $stable(source_channel) && $stable(source_aggregate_bus);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed before transfer");

  property p_sop_zero;
    @(posedge pclk) disable iff (!presetn)
    source_valid |-> source_sop == (source_channel == FIRST_CH);
  endproperty
  a_sop_zero: assert property (p_sop_zero) else $error("sop does not match channel");

  property p_eop_last;
    @(posedge pclk) disable iff (!presetn)
    source_valid |-> source_eop == (source_channel == LAST_CH);
  endproperty
  a_eop_last: assert property (p_eop_last) else $error("eop does not match channel");

  property p_take_result;
    @(posedge pclk) disable iff (!presetn)
    take |=> source_valid && source_channel == $past(beat.chan) &&
             source_error == $past(beat.err_out);
  endproperty
  a_take_result: assert property (p_take_result) else $error("taken beat not shown");

  property p_sop_chan;
    @(posedge pclk) disable iff (!presetn)
    take && sink_sop |=> source_channel == FIRST_CH && source_sop;
  endproperty
  a_sop_chan: assert property (p_sop_chan) else $error("start beat not channel zero");

  property p_halt;
    @(posedge pclk) disable iff (!presetn)
    !sink_valid |=> $stable(beat_count) && $stable(source_aggregate_bus);
  endproperty
  a_halt: assert property (p_halt) else $error("advanced without valid");

  property p_msb_slot;
    @(posedge pclk) disable iff (!presetn)
    take |=> source_aggregate_bus[NUM_IF*OUT_W-1 -: OUT_W] == result_output_port[0] &&
             source_aggregate_bus[OUT_W-1:0] == result_output_port[NUM_IF-1];
  endproperty
  a_msb_slot: assert property (p_msb_slot) else $error("interface slot order wrong");

  property p_clken;
    @(posedge pclk) disable iff (!presetn)
    !clken |=> $stable(source_valid) && $stable(beat_count);
  endproperty
  a_clken: assert property (p_clken) else $error("advanced with clken low");

  property p_reset_clean;
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> !source_valid && source_error == ERR_NONE && !sink_ready;
  endproperty
  a_reset_clean: assert property (p_reset_clean) else $error("dirty state after reset");
endmodule

// ===== hw/cicsp_pkg.sv
// shared constants and types of the stream port block
package cicsp_pkg;
  // apb bus shape
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  // register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFFSET   = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;
  localparam logic [ADDR_W-1:0] CHAN_OFFSET   = 8'h08;
  localparam logic [ADDR_W-1:0] BEATS_OFFSET  = 8'h0c;
  // control fields
  localparam int   CTRL_ENABLE_BIT   = 0;
  localparam logic CTRL_ENABLE_RESET = 1'h1;
  // sticky status fields
  localparam int STAT_NO_SOP_BIT   = 0;
  localparam int STAT_NO_EOP_BIT   = 1;
  localparam int STAT_OTHER_BIT    = 2;
  localparam int STAT_UPSTREAM_BIT = 3;
  localparam int STAT_W            = 4;
  // channel register: source channel field position
  localparam int CHAN_SRC_LSB = 16;
  localparam int CHAN_MAX_W   = 16;
  // two-bit error codes, same on sink and source
  localparam logic [1:0] ERR_NONE   = 2'h0;
  localparam logic [1:0] ERR_NO_SOP = 2'h1;
  localparam logic [1:0] ERR_NO_EOP = 2'h2;
  localparam logic [1:0] ERR_OTHER  = 2'h3;
  // default shape of the datapath
  localparam int NUM_IF_DEFAULT = 2;
  localparam int NUM_CH_DEFAULT = 4;
  localparam int IN_W_DEFAULT   = 16;
  localparam int OUT_W_DEFAULT  = 18;
  // framing state of the sink
  typedef enum logic {
    FRAME_IDLE,
    FRAME_BUSY
  } cicsp_frame_type;
endpackage

// ===== hw/cicsp_beat_if.sv
// beat handshake between the port logic and the framing checker
`timescale 1ns/1ps
interface cicsp_beat_if #(
  parameter int CH_W = 2
);
  logic            accept;      // sink beat taken this cycle
  logic            sop;         // start marker of that beat
  logic            eop;         // end marker of that beat
  logic [1:0]      err_in;      // upstream error code
  logic [CH_W-1:0] chan;        // channel of that beat
  logic [1:0]      err_out;     // framing class of that beat
  logic [CH_W-1:0] expect_chan; // next channel expected
  modport port (output accept, sop, eop, err_in, input chan, err_out, expect_chan);
  modport check (input accept, sop, eop, err_in, output chan, err_out, expect_chan);
endinterface

// ===== hw/cicsp_frame_check.sv
// framing checker: channel tracking and error class of sink beats
`timescale 1ns/1ps
module cicsp_frame_check #(
  parameter int NUM_CH = cicsp_pkg::NUM_CH_DEFAULT, // channels per interface
  parameter int CH_W   = 2                          // channel index width
) (
  input wire logic    pclk,    // the only clock
  input wire logic    presetn, // async reset, active low
  cicsp_beat_if.check beat     // beat from the port logic
);
  import cicsp_pkg::*;

  localparam logic [CH_W-1:0] LAST_CH = CH_W'(NUM_CH - 1);

  cicsp_frame_type frame;
  logic [CH_W-1:0] count;
  logic            at_last;
  logic            closes;

  assign beat.chan        = beat.sop ? '0 : count;
  assign beat.expect_chan = count;
  assign at_last          = (beat.chan == LAST_CH);
  // packet closes on eop or on the last channel, so a lost eop resyncs
  assign closes           = beat.eop | at_last;

  always_comb begin
    beat.err_out = ERR_NONE;
    if (beat.err_in != ERR_NONE) begin
      beat.err_out = beat.err_in;
    end else if (beat.sop && frame == FRAME_BUSY) begin
      beat.err_out = ERR_NO_EOP;
    end else if (!beat.sop && frame == FRAME_IDLE) begin
      beat.err_out = ERR_NO_SOP;
    end else if (beat.eop && !at_last) begin
      beat.err_out = ERR_OTHER;
    end else if (!beat.eop && at_last) begin
      beat.err_out = ERR_NO_EOP;
    end
  end

  // framing state, moves only on taken beats
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame <= FRAME_IDLE;
    end else begin
      case (frame)
        FRAME_IDLE: if (beat.accept && !closes) frame <= FRAME_BUSY;
        FRAME_BUSY: if (beat.accept && closes) frame <= FRAME_IDLE;
        default:    frame <= FRAME_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (beat.accept) begin
      count <= closes ? '0 : beat.chan + CH_W'(1);
    end
  end

  property p_chan_step;
    @(posedge pclk) disable iff (!presetn)
    beat.accept && !closes |=> beat.expect_chan == CH_W'($past(beat.chan) + 1);
  endproperty
  a_chan_step: assert property (p_chan_step) else $error("channel did not step");

  // takes are never back to back, so judge a headless beat while no packet is open
  property p_no_sop;
    @(posedge pclk) disable iff (!presetn)
    beat.accept && !beat.sop && beat.err_in == ERR_NONE && frame == FRAME_IDLE |->
      beat.err_out == ERR_NO_SOP;
  endproperty
  a_no_sop: assert property (p_no_sop) else $error("missing sop not flagged");
endmodule

// ===== verification/cicsp_sink_model.sv
// downstream result taker with prompt or stalling ready
`timescale 1ns/1ps
module cicsp_sink_model (
  input  wire logic pclk,        // the only clock
  input  wire logic presetn,     // async reset, active low
  input  wire logic slow,        // stall two cycles of three
  output logic      source_ready // ready toward the block
);
  logic [1:0] phase; // stall pattern position

  // stall pattern, moves on every edge like a real taker would
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 2'h0;
    end else begin
      phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
    end
  end

  assign source_ready = !slow || (phase == 2'h2);
endmodule

// ===== verification/tb_cicsp_top.sv
// self-checking bench of the stream port block
`timescale 1ns/1ps
module tb_cicsp_top;
  import cicsp_pkg::*;
  localparam int NI = 2;
  localparam int NC = 4;
  localparam int IW = 16;
  localparam int OW = 18;
  // stimulus and observed signals
  logic              pclk       = 1'b0;
  logic              presetn    = 1'b0;
  logic [ADDR_W-1:0] paddr      = '0;
  logic              psel       = 1'b0;
  logic              penable    = 1'b0;
  logic              pwrite     = 1'b0;
  logic [DATA_W-1:0] pwdata     = '0;
  logic              clken      = 1'b1;
  logic [IW-1:0]     si [NI]    = '{default: '0};
  logic              sink_valid = 1'b0;
  logic              sink_sop   = 1'b0;
  logic              sink_eop   = 1'b0;
  logic [1:0]        sink_error = 2'h0;
  logic              slow       = 1'b0;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              sink_ready;
  logic [NI*IW-1:0]  sink_aggregate_bus;
  logic [OW-1:0]     ro [NI];
  logic [NI*OW-1:0]  source_aggregate_bus;
  logic              source_valid;
  logic              source_ready;
  logic              source_sop;
  logic              source_eop;
  logic [1:0]        source_error;
  logic [1:0]        source_channel;
  logic [DATA_W-1:0] rd;
  logic              er;
  logic [IW-1:0]     s0;
  logic [IW-1:0]     s1;
  int                n_errors   = 0;
  int                tests_run  = 0;
  int                cycles     = 0;
  int                seq        = 0;

  always #2.5 pclk = ~pclk;

  cicsp_top u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .clken(clken), .sample_input_port(si),
    .sink_valid(sink_valid), .sink_sop(sink_sop), .sink_eop(sink_eop),
    .sink_error(sink_error), .sink_ready(sink_ready),
    .sink_aggregate_bus(sink_aggregate_bus), .result_output_port(ro),
    .source_aggregate_bus(source_aggregate_bus), .source_valid(source_valid),
    .source_ready(source_ready), .source_sop(source_sop), .source_eop(source_eop),
    .source_error(source_error), .source_channel(source_channel));

  cicsp_sink_model u_sink (.pclk(pclk), .presetn(presetn), .slow(slow),
    .source_ready(source_ready));

  task automatic complete_run();
    $display("mismatches %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    tests_run++;
    if (seen !== want) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  function automatic logic [OW-1:0] ext(input logic [IW-1:0] v);
    return {{(OW-IW){v[IW-1]}}, v};
  endfunction

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    check(source_valid, 1'b0);
    check(source_error, ERR_NONE);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  // one apb transfer; waits for pready, only the hang guard ends a wait
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic send(input logic sop, input logic eop, input logic [1:0] e);
    s0 = 16'h8000 + 16'(seq);
    s1 = 16'h0120 + 16'(seq);
    seq++;
    sink_valid <= 1'b1;
    sink_sop <= sop;
    sink_eop <= eop;
    sink_error <= e;
    si[0] <= s0;
    si[1] <= s1;
    do @(posedge pclk); while (!(sink_ready === 1'b1 && clken === 1'b1));
    // released samples flip so a stale copy cannot pass
    sink_valid <= 1'b0;
    si[0] <= ~s0;
    si[1] <= ~s1;
  endtask

  task automatic recv(input logic [1:0] ch, input logic [1:0] e);
    do @(negedge pclk); while (!(source_valid === 1'b1 && source_ready === 1'b1 && clken));
    check(ro[0], ext(s0));
    check(ro[1], ext(s1));
    check(source_aggregate_bus, {ext(s0), ext(s1)});
    check(sink_aggregate_bus, {s0, s1});
    check(source_channel, ch);
    check(source_sop, ch == 2'h0);
    check(source_eop, ch == 2'(NC-1));
    check(source_error, e);
    check(sink_ready, 1'b0);
    @(posedge pclk);
  endtask

  task automatic beat(input logic sop, eop, input logic [1:0] e, ch, ee);
    send(sop, eop, e);
    recv(ch, ee);
  endtask

  task automatic t_regs();
    do_reset();
    apb(1'b0, CTRL_OFFSET, '0);
    check(rd[CTRL_ENABLE_BIT], CTRL_ENABLE_RESET);
    apb(1'b0, 8'h10, '0);
    check({er, rd}, {1'b1, 32'h0});
    apb(1'b1, CTRL_OFFSET, '0);
    repeat (3) @(negedge pclk);
    check(sink_ready, 1'b0);
    apb(1'b1, CTRL_OFFSET, 32'h1);
    beat(1'b1, 1'b1, 2'h0, 2'h0, ERR_OTHER);
    apb(1'b0, STATUS_OFFSET, '0);
    check(rd[STAT_W-1:0], 4'h4);
    apb(1'b1, STATUS_OFFSET, 32'h4);
    apb(1'b0, STATUS_OFFSET, '0);
    check(rd, 32'h0);
    apb(1'b0, BEATS_OFFSET, '0);
    check(rd, 32'h1);
  endtask

  // end marker on last channel only when asked
  task automatic t_packet(input logic sl, input logic eop_ok);
    slow <= sl;
    for (int c = 0; c < NC; c++) begin
      beat(c == 0, eop_ok && c == NC-1, 2'h0, 2'(c),
        (!eop_ok && c == NC-1) ? ERR_NO_EOP : ERR_NONE);
    end
    repeat (5) @(negedge pclk);
    check(source_valid, 1'b0);
    @(posedge pclk);
  endtask

  task automatic t_errs();
    do_reset();
    beat(1'b0, 1'b0, 2'h0, 2'h0, ERR_NO_SOP);
    do_reset();
    beat(1'b1, 1'b0, 2'h2, 2'h0, 2'h2);
    // passed-through code sets missing-eop and upstream flags
    apb(1'b0, STATUS_OFFSET, '0);
    check(rd[STAT_W-1:0], 4'ha);
    do_reset();
    beat(1'b1, 1'b0, 2'h0, 2'h0, ERR_NONE);
    beat(1'b1, 1'b0, 2'h0, 2'h0, ERR_NO_EOP);
    apb(1'b0, STATUS_OFFSET, '0);
    check(rd[STAT_W-1:0], 4'h2);
  endtask

  task automatic t_clken();
    do_reset();
    slow <= 1'b0;
    send(1'b1, 1'b0, 2'h0);
    clken <= 1'b0;
    repeat (4) @(negedge pclk);
    check(source_valid, 1'b1);
    @(posedge pclk);
    clken <= 1'b1;
    recv(2'h0, ERR_NONE);
    beat(1'b0, 1'b0, 2'h0, 2'h1, ERR_NONE);
    // next expected sink channel 2, last source channel 1
    apb(1'b0, CHAN_OFFSET, '0);
    check(rd, 32'h0001_0002);
  endtask

  initial begin
    t_regs();
    t_packet(1'b0, 1'b1);
    t_packet(1'b1, 1'b1);
    t_packet(1'b1, 1'b0);
    t_errs();
    t_clken();
    complete_run();
  end
endmodule
